/* hw/burst_mod_regs.svh */
`ifndef BURST_MOD_REGS_SVH
`define BURST_MOD_REGS_SVH
// ----------------------------------------
// configuration bit that selects the extra pipeline delay
// ----------------------------------------
`define MOD_CFG_REG 8'h36
`define MOD_CFG_DELAY_BIT 6
// ----------------------------------------
// timing counts, in transmit bit clock cycles or symbols; SRC_HALF_DIV in sys_clk cycles per half bit clock
// ----------------------------------------
`define MOD_EXTRA_DELAY 8
`define MOD_LEAD_SYMS 2
`define MOD_TAIL_SYMS 13
`define MOD_PRE_SYMS 14
`define MOD_BITS_PER_SYM 2
`define SRC_HALF_DIV 4
// ----------------------------------------
// counter widths
// ----------------------------------------
`define SRC_CNT_W 18
`define MOD_CNT_W 8
`define MOD_SYM_W 4
`define DIV_W 8
`endif

/* hw/burst_mod_pkg.sv */
`include "burst_mod_regs.svh"
package burst_mod_pkg;
  typedef enum logic [2:0] {SRC_IDLE, SRC_LEAD, SRC_XFER, SRC_TAIL} src_state_t;
  typedef enum logic [2:0] {MOD_IDLE, MOD_LEAD, MOD_ACTIVE, MOD_TRAIL, MOD_SHIFT} mod_state_t;
  typedef enum logic [1:0] {DIFF_HOLD, DIFF_TOGGLE, DIFF_ZEROREF} diff_mode_t;

  typedef struct packed {
    src_state_t st;
    logic [`DIV_W-1:0] div;
    logic clk;
    logic gate;
    logic win;
    logic data;
    logic diff;
    logic fec;
    logic rnd;
    logic dsel;
    logic [`SRC_CNT_W-1:0] bit_idx;
    logic [`SRC_CNT_W-1:0] nbits;
    logic fec_on;
    diff_mode_t dmode;
    logic dlvl;
    logic seen_out;
    logic done;
  } src_state_s_t;

  // link inputs as seen by the modulator: clk,gate,win,data,diff,fec,rnd,dsel
  typedef struct packed {
    mod_state_t st;
    logic [7:0] s1;
    logic [7:0] s2;
    logic clk_prev;
    logic [`MOD_CNT_W-1:0] cnt;
    logic [`MOD_SYM_W-1:0] sym;
    logic out_win;
    logic rx_bit;
    logic rx_valid;
    logic sym_pulse;
    logic rx_diff;
    logic rx_fec;
    logic rx_rand;
  } mod_state_s_t;
endpackage : burst_mod_pkg

/* hw/burst_link_if.sv */
`timescale 1ns/1ps
interface burst_link_if;
  logic tx_bit_clock;
  logic clock_gate_enable;
  logic burst_data_window;
  logic serial_data;
  logic diff_encode_enable;
  logic fec_encoder_enable;
  logic randomizer_enable;
  logic delay_sel;
  logic modulator_output_window;

  modport source (
    output tx_bit_clock, clock_gate_enable, burst_data_window, serial_data,
    output diff_encode_enable, fec_encoder_enable, randomizer_enable, delay_sel,
    input modulator_output_window
  );
  modport modulator (
    input tx_bit_clock, clock_gate_enable, burst_data_window, serial_data,
    input diff_encode_enable, fec_encoder_enable, randomizer_enable, delay_sel,
    output modulator_output_window
  );
endinterface : burst_link_if

/* hw/burst_source.sv */
// Overview of operation
// - data changes on falling edge, sampled rising
// - delay bit clear: minimum delay, no FEC
// - delay bit set: output window eight cycles later
// - delay bit set whenever FEC encoder used
// - diff enable toggles or holds per encoding
// - first preamble bit starts on falling edge
// - clock gate up by first preamble edge
// - data window rises mid first preamble bit
// - output window rises ending second symbol
// - diff enable rises one symbol before user
// - data may vanish after last sampling edge
// - diff enable falls at last user symbol
// - data window falls cycle after last bit
// - clock gate held until output window low
// - output window held thirteen symbol pulses
// - FEC and randomizer rise at user start
// - FEC enable falls at last user symbol
// - randomizer falls cycle after last bit
// - zero-reference mode: diff rises at user start
// - bit clock may stop after output window falls
// - output window edges synchronized to clock
`timescale 1ns/1ps
`include "burst_mod_regs.svh"
module burst_source #(
  parameter int PRE_SYMS = `MOD_PRE_SYMS,
  parameter int BPS = `MOD_BITS_PER_SYM,
  parameter int HALF_DIV = `SRC_HALF_DIV
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  burst_link_if.source link,
  input wire logic start,
  input wire logic [13:0] user_syms,
  input wire logic fec_req,
  input wire logic [1:0] diff_mode,
  input wire logic diff_level,
  input wire logic bit_in,
  output logic bit_req,
  output logic busy,
  output logic done
);
  // ----------------------------------------
  // parameter checks
  // ----------------------------------------
  if (PRE_SYMS < 1 || PRE_SYMS > 255) begin : g_chk_pre
    $error("PRE_SYMS out of range");
  end
  if (BPS < 1 || BPS > 8) begin : g_chk_bps
    $error("BPS out of range");
  end
  if (HALF_DIV < 1 || HALF_DIV > 255) begin : g_chk_div
    $error("HALF_DIV out of range");
  end

  // ----------------------------------------
  // derived constants
  // ----------------------------------------
  // bits are counted from zero across preamble and user data
  localparam logic [`SRC_CNT_W-1:0] BPS_C = `SRC_CNT_W'(BPS);
  localparam logic [`SRC_CNT_W-1:0] UBASE = `SRC_CNT_W'(PRE_SYMS * BPS);
  localparam logic [`DIV_W-1:0] DIV_END = `DIV_W'(HALF_DIV - 1);

  // ----------------------------------------
  // state and helpers
  // ----------------------------------------
  burst_mod_pkg::src_state_s_t q, d;
  logic tick;
  logic rise_ev;
  logic fall_ev;
  logic more_bits;
  logic [`SRC_CNT_W-1:0] last_sym;
  logic [`SRC_CNT_W-1:0] next_idx;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    d = q;
    d.done = 1'b0;
    // ----------------------------------------
    // bit clock divider
    // ----------------------------------------
    tick = (q.st != burst_mod_pkg::SRC_IDLE) && (q.div == DIV_END);
    rise_ev = tick && !q.clk;
    fall_ev = tick && q.clk;
    next_idx = q.bit_idx + `SRC_CNT_W'(1);
    last_sym = q.nbits - BPS_C;
    more_bits = next_idx < q.nbits;
    bit_req = fall_ev && ((q.st == burst_mod_pkg::SRC_LEAD) ||
              (q.st == burst_mod_pkg::SRC_XFER && more_bits));
    if (q.st != burst_mod_pkg::SRC_IDLE) begin
      d.div = tick ? '0 : q.div + `DIV_W'(1);
      if (tick) begin
        d.clk = !q.clk;
      end
    end
    // ----------------------------------------
    // burst sequencing
    // ----------------------------------------
    case (q.st)
      burst_mod_pkg::SRC_IDLE: begin
        // start is only looked at here, so a start while a burst runs is dropped
        // the burst settings are latched so later input changes cannot disturb it
        d.div = '0;
        d.clk = 1'b0;
        if (start) begin
          d.st = burst_mod_pkg::SRC_LEAD;
          d.nbits = `SRC_CNT_W'((`SRC_CNT_W'(PRE_SYMS) + `SRC_CNT_W'(user_syms)) * BPS_C);
          d.fec_on = fec_req;
          d.dsel = fec_req;
          d.dmode = burst_mod_pkg::diff_mode_t'(diff_mode);
          d.dlvl = diff_level;
          d.diff = (diff_mode == 2'(burst_mod_pkg::DIFF_HOLD)) ? diff_level : 1'b0;
          d.seen_out = 1'b0;
          d.bit_idx = '0;
        end
      end
      burst_mod_pkg::SRC_LEAD: begin
        // gate and first preamble bit leave together on the first falling edge
        if (fall_ev) begin
          d.st = burst_mod_pkg::SRC_XFER;
          d.gate = 1'b1;
          d.data = bit_in;
          d.bit_idx = '0;
        end
      end
      burst_mod_pkg::SRC_XFER: begin
        // data moves on falling edges, the control levels on rising edges except the zero-reference diff rise, which is on a falling edge
        if (fall_ev) begin
          d.bit_idx = next_idx;
          d.data = more_bits ? bit_in : 1'b0;
          if (q.dmode == burst_mod_pkg::DIFF_ZEROREF && next_idx == UBASE) begin
            d.diff = 1'b1;
          end
        end
        if (rise_ev) begin
          if (q.bit_idx == '0) begin
            d.win = 1'b1;
          end
          if (q.dmode == burst_mod_pkg::DIFF_TOGGLE && q.bit_idx == UBASE - BPS_C) begin
            d.diff = 1'b1;
          end
          if (q.bit_idx == UBASE) begin
            d.fec = q.fec_on;
            d.rnd = 1'b1;
          end
          // the last user symbol starts BPS bits before the end
          if (q.bit_idx == last_sym) begin
            d.fec = 1'b0;
            if (q.dmode != burst_mod_pkg::DIFF_HOLD) begin
              d.diff = 1'b0;
            end
          end
          if (q.bit_idx == q.nbits) begin
            d.win = 1'b0;
            d.rnd = 1'b0;
            d.st = burst_mod_pkg::SRC_TAIL;
          end
        end
      end
      burst_mod_pkg::SRC_TAIL: begin
        // the window is down; only the output window is watched from here
        // the modulator counts its tail symbols on this clock, so it keeps running
        if (link.modulator_output_window) begin
          d.seen_out = 1'b1;
        end
        if (fall_ev && q.seen_out && !link.modulator_output_window) begin
          d.st = burst_mod_pkg::SRC_IDLE;
          d.gate = 1'b0;
          d.diff = 1'b0;
          d.done = 1'b1;
        end
      end
      default: begin
        d.st = burst_mod_pkg::SRC_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign link.tx_bit_clock = q.clk;
  assign link.clock_gate_enable = q.gate;
  assign link.burst_data_window = q.win;
  assign link.serial_data = q.data;
  assign link.diff_encode_enable = q.diff;
  assign link.fec_encoder_enable = q.fec;
  assign link.randomizer_enable = q.rnd;
  assign link.delay_sel = q.dsel;

  // ----------------------------------------
  // status
  // ----------------------------------------
  assign busy = q.st != burst_mod_pkg::SRC_IDLE;
  assign done = q.done;
endmodule : burst_source

/* hw/burst_modulator.sv */
`timescale 1ns/1ps
`include "burst_mod_regs.svh"
module burst_modulator #(
  parameter int BPS = `MOD_BITS_PER_SYM
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  burst_link_if.modulator link,
  output logic rx_bit,
  output logic rx_valid,
  output logic symbol_pulse,
  output logic rx_diff,
  output logic rx_fec,
  output logic rx_rand,
  output logic cfg_delay
);
  if (BPS < 1 || BPS > 8) begin : g_chk_bps
    $error("BPS out of range");
  end

  localparam logic [`MOD_SYM_W-1:0] BPS_C = `MOD_SYM_W'(BPS);
  localparam logic [`MOD_CNT_W-1:0] LEAD_MIN = `MOD_CNT_W'(`MOD_LEAD_SYMS * BPS);
  localparam logic [`MOD_CNT_W-1:0] XTRA = `MOD_CNT_W'(`MOD_EXTRA_DELAY);
  localparam logic [`MOD_CNT_W-1:0] TAIL = `MOD_CNT_W'(`MOD_TAIL_SYMS);

  burst_mod_pkg::mod_state_s_t q, d;
  logic s_clk, s_gate, s_win, s_data, s_diff, s_fec, s_rnd, s_dsel;
  logic rise_ev;
  logic fall_ev;
  logic sym_ev;
  logic [`MOD_CNT_W-1:0] lead_n;

  assign {s_clk, s_gate, s_win, s_data, s_diff, s_fec, s_rnd, s_dsel} = q.s2;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    d = q;
    // every link pin passes two flops before use
    d.s1 = {link.tx_bit_clock, link.clock_gate_enable, link.burst_data_window, link.serial_data,
            link.diff_encode_enable, link.fec_encoder_enable, link.randomizer_enable, link.delay_sel};
    d.s2 = q.s1;
    d.clk_prev = s_clk;
    d.rx_valid = 1'b0;
    d.sym_pulse = 1'b0;
    rise_ev = s_clk && !q.clk_prev && s_gate;
    fall_ev = !s_clk && q.clk_prev && s_gate;
    sym_ev = rise_ev && (q.sym + `MOD_SYM_W'(1) == BPS_C);
    lead_n = LEAD_MIN + (s_dsel ? XTRA : '0);
    if (q.st != burst_mod_pkg::MOD_IDLE && rise_ev) begin
      d.sym = sym_ev ? '0 : q.sym + `MOD_SYM_W'(1);
      d.sym_pulse = sym_ev;
    end
    if (rise_ev && s_win) begin
      d.rx_bit = s_data;
      d.rx_valid = 1'b1;
      d.rx_diff = s_diff;
      d.rx_fec = s_fec;
      d.rx_rand = s_rnd;
    end
    case (q.st)
      burst_mod_pkg::MOD_IDLE: begin
        d.out_win = 1'b0;
        if (rise_ev && s_win) begin
          d.st = burst_mod_pkg::MOD_LEAD;
          d.cnt = '0;
          d.sym = (BPS_C == `MOD_SYM_W'(1)) ? '0 : `MOD_SYM_W'(1);
          d.sym_pulse = BPS_C == `MOD_SYM_W'(1);
        end
      end
      burst_mod_pkg::MOD_LEAD: begin
        if (fall_ev) begin
          d.cnt = q.cnt + `MOD_CNT_W'(1);
          if (q.cnt + `MOD_CNT_W'(1) == lead_n) begin
            d.out_win = 1'b1;
            d.st = burst_mod_pkg::MOD_ACTIVE;
          end
        end
      end
      burst_mod_pkg::MOD_ACTIVE: begin
        if (!s_win) begin
          d.st = burst_mod_pkg::MOD_TRAIL;
          d.cnt = '0;
        end
      end
      burst_mod_pkg::MOD_TRAIL: begin
        if (sym_ev) begin
          d.cnt = q.cnt + `MOD_CNT_W'(1);
          if (q.cnt + `MOD_CNT_W'(1) == TAIL) begin
            d.st = burst_mod_pkg::MOD_SHIFT;
            d.cnt = s_dsel ? XTRA : '0;
          end
        end
      end
      burst_mod_pkg::MOD_SHIFT: begin
        // the fall waits for a clock edge so both edges stay on the bit grid
        if (fall_ev) begin
          if (q.cnt == '0) begin
            d.out_win = 1'b0;
            d.st = burst_mod_pkg::MOD_IDLE;
          end else begin
            d.cnt = q.cnt - `MOD_CNT_W'(1);
          end
        end
      end
      default: begin
        d.st = burst_mod_pkg::MOD_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign link.modulator_output_window = q.out_win;
  assign rx_bit = q.rx_bit;
  assign rx_valid = q.rx_valid;
  assign symbol_pulse = q.sym_pulse;
  assign rx_diff = q.rx_diff;
  assign rx_fec = q.rx_fec;
  assign rx_rand = q.rx_rand;
  assign cfg_delay = s_dsel;
endmodule : burst_modulator

/* sim/burst_link_assertions.sv */
`timescale 1ns/1ps
module burst_link_assertions (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic tx_bit_clock,
  input wire logic clock_gate_enable,
  input wire logic burst_data_window,
  input wire logic serial_data,
  input wire logic diff_encode_enable,
  input wire logic fec_encoder_enable,
  input wire logic randomizer_enable,
  input wire logic delay_sel,
  input wire logic modulator_output_window
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // helper: a burst window has been offered since reset
  // ----------------------------------------
  logic seen_q;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) seen_q <= 1'b0;
    else if (burst_data_window) seen_q <= 1'b1;
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  property p_data_fall;
    $changed(serial_data) && burst_data_window && $past(burst_data_window) |-> $fell(tx_bit_clock);
  endproperty
  a_data_fall: assert property (p_data_fall) else $error("data moved off a falling clock");
  property p_gate_first;
    $rose(burst_data_window) |-> clock_gate_enable;
  endproperty
  a_gate_first: assert property (p_gate_first) else $error("gate low at window start");
  property p_win_rise;
    $rose(burst_data_window) |-> $rose(tx_bit_clock);
  endproperty
  a_win_rise: assert property (p_win_rise) else $error("window rose off a rising clock");
  property p_win_end;
    $fell(burst_data_window) |-> $rose(tx_bit_clock) && $fell(randomizer_enable);
  endproperty
  a_win_end: assert property (p_win_end) else $error("window end misaligned");
  property p_fec_start;
    $rose(fec_encoder_enable) |-> $rose(randomizer_enable) && $rose(tx_bit_clock);
  endproperty
  a_fec_start: assert property (p_fec_start) else $error("fec start misaligned");
  property p_fec_end;
    $fell(fec_encoder_enable) |-> $rose(tx_bit_clock) && burst_data_window;
  endproperty
  a_fec_end: assert property (p_fec_end) else $error("fec end misaligned");
  property p_fec_cfg;
    fec_encoder_enable |-> delay_sel;
  endproperty
  a_fec_cfg: assert property (p_fec_cfg) else $error("fec without extra delay");
  property p_gate_hold;
    $fell(clock_gate_enable) |-> !modulator_output_window;
  endproperty
  a_gate_hold: assert property (p_gate_hold) else $error("gate dropped under output window");
  // output edges trail a falling clock by a few cycles, inside the low half
  property p_out_sync;
    $changed(modulator_output_window) |-> !tx_bit_clock && $past(tx_bit_clock, 5);
  endproperty
  a_out_sync: assert property (p_out_sync) else $error("output window edge unsynchronised");
  property p_out_reset;
    modulator_output_window |-> seen_q;
  endproperty
  a_out_reset: assert property (p_out_reset) else $error("output window before any burst");
  c_out_delay: cover property ($rose(modulator_output_window) && delay_sel);
  c_out_min: cover property ($rose(modulator_output_window) && !delay_sel);
  c_fec_end: cover property ($fell(fec_encoder_enable));
endmodule : burst_link_assertions

/* sim/burst_modulator_input_timing_bench.sv */
`timescale 1ns/1ps
module burst_modulator_input_timing_bench;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic start = 1'b0;
  logic [13:0] user_syms = 14'h0001;
  logic fec_req = 1'b0;
  logic [1:0] diff_mode = 2'h0;
  logic diff_level = 1'b0;
  logic bit_in = 1'b0;
  logic tx_bit_clock_q = 1'b0;
  logic bit_req, busy, done, rx_bit, rx_valid, rx_diff, rx_fec, rx_rand, cfg_delay, sym_pulse;
  logic [7:0] pat = 8'hb4;
  logic exp_q[$];
  int mismatches = 0;
  int comparisons = 0;
  int cycles = 0;
  int bidx = 0;
  int nfall, nbit, nfec, nrnd, ndif, nsym;
  always #10 sys_clk = ~sys_clk;
  // ----------------------------------------
  // the two ends and the link checker
  // ----------------------------------------
  burst_link_if link();
  // slower bit clock keeps output window edges inside the low half
  burst_source #(.HALF_DIV(8)) u_burst_source (.sys_clk(sys_clk), .rst_n(rst_n), .link(link), .start(start),
    .user_syms(user_syms), .fec_req(fec_req), .diff_mode(diff_mode), .diff_level(diff_level), .bit_in(bit_in),
    .bit_req(bit_req), .busy(busy), .done(done));
  burst_modulator u_burst_modulator (.sys_clk(sys_clk), .rst_n(rst_n), .link(link), .rx_bit(rx_bit),
    .rx_valid(rx_valid), .symbol_pulse(sym_pulse), .rx_diff(rx_diff), .rx_fec(rx_fec), .rx_rand(rx_rand),
    .cfg_delay(cfg_delay));
  burst_link_assertions u_burst_link_assertions (.sys_clk(sys_clk), .rst_n(rst_n),
    .tx_bit_clock(link.tx_bit_clock), .clock_gate_enable(link.clock_gate_enable),
    .burst_data_window(link.burst_data_window), .serial_data(link.serial_data),
    .diff_encode_enable(link.diff_encode_enable), .fec_encoder_enable(link.fec_encoder_enable),
    .randomizer_enable(link.randomizer_enable), .delay_sel(link.delay_sel),
    .modulator_output_window(link.modulator_output_window));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic conclude();
    $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude
  // ----------------------------------------
  // monitor: bit feed, received bits, edge counts
  // ----------------------------------------
  always @(posedge sys_clk) begin
    cycles++;
    tx_bit_clock_q <= link.tx_bit_clock;
    if (tx_bit_clock_q && !link.tx_bit_clock && link.burst_data_window && !link.modulator_output_window) nfall++;
    if (bit_req === 1'b1) begin
      exp_q.push_back(bit_in);
      bidx <= bidx + 1;
      bit_in <= pat[(bidx + 1) % 8];
    end
    if (rx_valid === 1'b1) begin
      nbit++;
      nfec += int'(rx_fec);
      nrnd += int'(rx_rand);
      ndif += int'(rx_diff);
      nsym += int'(sym_pulse);
      check(32'(rx_bit), 32'(exp_q.pop_front()));
    end
    if (cycles == 20000) begin
      mismatches++;
      conclude();
    end
  end
  // a second start mid-burst must be ignored, so bit counts still match one burst
  task automatic run_burst(input int n, input logic f, input logic [1:0] m, input logic l, input logic dup);
    @(negedge sys_clk);
    nfall = 0; nbit = 0; nfec = 0; nrnd = 0; ndif = 0; nsym = 0;
    @(posedge sys_clk);
    start <= 1'b1; user_syms <= 14'(n); fec_req <= f; diff_mode <= m; diff_level <= l;
    @(posedge sys_clk);
    start <= 1'b0;
    if (dup) begin
      repeat (40) @(posedge sys_clk);
      start <= 1'b1; user_syms <= 14'h0009;
      @(posedge sys_clk);
      start <= 1'b0;
    end
    do @(posedge sys_clk); while (done !== 1'b1);
    check(nbit, (14 + n) * 2);
    check(nrnd, n * 2);
    check(32'(cfg_delay), 32'(f));
    check(nsym, 14 + n);
    @(posedge sys_clk);
    check(32'(busy), 32'h0000_0000);
  endtask : run_burst
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_min();
    run_burst(1, 1'b0, 2'h0, 1'b0, 1'b0);
    check(nfall, 4);
    check(nfec, 0);
    check(ndif, 0);
  endtask : t_min
  task automatic t_fec();
    run_burst(3, 1'b1, 2'h1, 1'b0, 1'b1);
    check(nfall, 12);
    check(nfec, 4);
    check(ndif, 6);
  endtask : t_fec
  task automatic t_zero();
    run_burst(2, 1'b0, 2'h2, 1'b0, 1'b0);
    check(ndif, 2);
    check(nfall, 4);
  endtask : t_zero
  task automatic t_hold();
    run_burst(2, 1'b1, 2'h0, 1'b1, 1'b0);
    check(ndif, 32);
    check(nfec, 2);
    check(nfall, 12);
  endtask : t_hold
  initial begin
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_min();
    t_fec();
    t_zero();
    t_hold();
    conclude();
  end
endmodule : burst_modulator_input_timing_bench
